// ### hdl/compare_channel.v
/*
  one compare channel: match detection against the selected time base and
  the internal compare output latch.
  assumes count and tick come from timer logic on pclk; tick marks the cycle
  in which count shows a freshly incremented value.
*/
`timescale 1ns/1ps
`include "timer_compare_map.vh"

module compare_channel (
  input wire pclk,
  input wire presetn,
  input wire [3:0] mode,
  input wire ctrl_zero_wr,
  input wire [15:0] compare_value,
  input wire [15:0] count,
  input wire tick,
  output wire match,
  output reg compare_latch
);

  // every compare sub-mode counts as compare here
  wire is_compare;
  assign is_compare = (mode == `MODE_TOGGLE) || (mode == `MODE_SET_HIGH) ||
                      (mode == `MODE_SET_LOW) || (mode == `MODE_SOFT_IRQ) ||
                      (mode == `MODE_SPECIAL);

  // qualified by tick so a held count matches only once
  assign match = tick & is_compare & (count == compare_value);

  // compare latch; a zero control write wins over a match in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_latch <= 1'b0;
    end else if (ctrl_zero_wr) begin
      compare_latch <= 1'b0;
    end else if (match) begin
      case (mode)
        `MODE_SET_HIGH: compare_latch <= 1'b1;
        `MODE_SET_LOW: compare_latch <= 1'b0;
        `MODE_TOGGLE: compare_latch <= ~compare_latch;
        default: compare_latch <= compare_latch;
      endcase
    end
  end

endmodule // compare_channel

// ### hdl/duty_pwm.v
/*
  one pulse-width channel with a 10-bit duty cycle, double-buffered.
  assumes fine_count is the period timer joined with its 2-bit fine count,
  and period_start pulses once at each period restart, both on pclk.
*/
`timescale 1ns/1ps

module duty_pwm #(
  parameter DUTY_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire [DUTY_W-1:0] duty,
  input wire [DUTY_W-1:0] fine_count,
  input wire period_start,
  output reg pwm_out
);

  // duty held for the running period so a mid-period write cannot glitch
  reg [DUTY_W-1:0] duty_held_reg;

  // set at period start unless duty is zero, cleared when the count reaches it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_held_reg <= {DUTY_W{1'b0}};
      pwm_out <= 1'b0;
    end else if (!enable) begin
      pwm_out <= 1'b0;
    end else if (period_start) begin
      duty_held_reg <= duty;
      pwm_out <= (duty != {DUTY_W{1'b0}});
    end else if (fine_count == duty_held_reg) begin
      pwm_out <= 1'b0;
    end
  end

endmodule // duty_pwm

// ### hdl/timer_compare_map.vh
/*
  register offsets, field positions, mode codes and reset values of the
  two-channel compare unit. definitions only; included by bare name.
*/
`ifndef TIMER_COMPARE_MAP_VH
`define TIMER_COMPARE_MAP_VH

// byte offsets on the apb slave, one aligned word each
`define OFS_SECOND_TIMER_CONTROL 8'h00
`define OFS_UNIT_ONE_VALUE_LOW 8'h04
`define OFS_UNIT_ONE_VALUE_HIGH 8'h08
`define OFS_UNIT_ONE_CONTROL 8'h0C
`define OFS_UNIT_TWO_VALUE_LOW 8'h10
`define OFS_UNIT_TWO_VALUE_HIGH 8'h14
`define OFS_UNIT_TWO_CONTROL 8'h18
`define OFS_MATCH_STATUS 8'h1C
`define OFS_MATCH_ENABLE 8'h20

// channel control fields
`define CTRL_MODE_LSB 0
`define CTRL_DUTY_LSB 4
`define CTRL_ENH_LSB 6

// timer-to-channel select bits in the second timer control
`define TSEL_LOW_BIT 3
`define TSEL_HIGH_BIT 6

// mode select codes
`define MODE_OFF 4'h0
`define MODE_TOGGLE 4'h2
`define MODE_SET_HIGH 4'h8
`define MODE_SET_LOW 4'h9
`define MODE_SOFT_IRQ 4'hA
`define MODE_SPECIAL 4'hB
`define MODE_PWM_TOP 2'b11

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

`endif

// ### hdl/timer_compare_unit.v
/*
  two-channel compare unit with special event trigger and pwm output,
  registers reached over an apb slave with zero wait states.
  assumes timers, port latch, direction bits and converter run on pclk.
*/
// Decided for this implementation: the address map and the APB register port.
// Functional notes
// - compare value against assigned timer continuously
// - match drives pin high, low, toggle, unchanged
// - match flag sets with pin action
// - zero control write forces compare latch low
// - mode 1010 touches no pin, only flag
// - interrupt request only with enable set
// - each channel has a special event trigger
// - special event trigger only in mode 1011
// - special event clears assigned time base
// - second channel trigger also starts conversion
// - pwm output with 10-bit duty resolution
// - mode in low four, duty bits above
// - unimplemented bits read as zero; channel one control 7:6 and spare timer control bits read back as written
// - timer select bits choose each time base
`timescale 1ns/1ps
`include "timer_compare_map.vh"

module timer_compare_unit #(
  parameter ADDR_W = 8,
  parameter DUTY_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] first_time_base,
  input wire first_time_base_tick,
  input wire [15:0] second_time_base,
  input wire second_time_base_tick,
  input wire [DUTY_W-1:0] pwm_fine_count,
  input wire pwm_period_start,
  input wire [1:0] port_latch,
  input wire [1:0] pin_direction_bits,
  output reg [1:0] channel_pin_out,
  output reg [1:0] channel_pin_oe,
  output reg [1:0] irq_req,
  output reg first_time_base_clear,
  output reg second_time_base_clear,
  output reg adc_start
);

  // register storage
  reg [7:0] second_timer_control_reg; // only the select bits steer logic here
  reg [15:0] value_reg [0:1]; // compare value pair per channel
  reg [7:0] control_reg [0:1]; // channel control per channel
  reg [1:0] match_flag_reg; // sticky match flags
  reg [1:0] match_flag_next;
  reg [1:0] match_irq_enable_reg; // per-channel interrupt enable

  // apb phase decode
  wire setup_ph;
  wire access_done;
  wire wr_en;
  reg [31:0] rd_data; // read mux result
  reg addr_hit; // address is mapped

  // per-channel views
  wire [1:0] match; // combinational match pulses
  wire [1:0] compare_latch; // internal compare output latches
  wire [1:0] pwm_out; // pwm waveforms
  wire [1:0] use_second; // channel runs on the second time base
  wire [1:0] special; // special event trigger per channel
  wire [1:0] pin_mode; // compare latch drives the pin
  wire [1:0] pwm_mode; // pwm owns the pin
  wire [3:0] mode_sel [0:1]; // mode select field per channel
  wire [1:0] ctrl_zero_wr; // whole-register zero write per channel
  wire [1:0] ctrl_wr; // control register write strobe
  wire [1:0] low_wr; // value low byte write strobe
  wire [1:0] high_wr; // value high byte write strobe
  wire tsel_low;
  wire tsel_high;

  assign setup_ph = psel & ~penable;
  // pready is raised for the first access cycle, so every transfer is two cycles
  assign access_done = psel & penable & pready;
  assign wr_en = access_done & pwrite & ~pslverr;

  assign tsel_low = second_timer_control_reg[`TSEL_LOW_BIT];
  assign tsel_high = second_timer_control_reg[`TSEL_HIGH_BIT];

  // high select gives both channels the second base; low only the second channel
  assign use_second[0] = tsel_high;
  assign use_second[1] = tsel_high | tsel_low;

  // strobes per channel, offsets spaced twelve bytes apart
  assign low_wr[0] = wr_en & (paddr == `OFS_UNIT_ONE_VALUE_LOW);
  assign high_wr[0] = wr_en & (paddr == `OFS_UNIT_ONE_VALUE_HIGH);
  assign ctrl_wr[0] = wr_en & (paddr == `OFS_UNIT_ONE_CONTROL);
  assign low_wr[1] = wr_en & (paddr == `OFS_UNIT_TWO_VALUE_LOW);
  assign high_wr[1] = wr_en & (paddr == `OFS_UNIT_TWO_VALUE_HIGH);
  assign ctrl_wr[1] = wr_en & (paddr == `OFS_UNIT_TWO_CONTROL);

  // channel logic, one copy per channel
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : chan
      wire [15:0] sel_count;
      wire sel_tick;
      wire [DUTY_W-1:0] duty;

      assign mode_sel[gi] = control_reg[gi][`CTRL_MODE_LSB +: 4];
      // only the full-zero write counts, partial clears keep the latch
      assign ctrl_zero_wr[gi] = ctrl_wr[gi] & (pwdata[7:0] == `RST_BYTE);
      assign sel_count = use_second[gi] ? second_time_base : first_time_base;
      assign sel_tick = use_second[gi] ? second_time_base_tick : first_time_base_tick;
      // duty: eight high bits from the value low byte, two from control
      assign duty = {value_reg[gi][7:0], control_reg[gi][`CTRL_DUTY_LSB +: 2]};
      assign pwm_mode[gi] = (mode_sel[gi][3:2] == `MODE_PWM_TOP);
      assign pin_mode[gi] = (mode_sel[gi] == `MODE_TOGGLE) ||
                            (mode_sel[gi] == `MODE_SET_HIGH) ||
                            (mode_sel[gi] == `MODE_SET_LOW);
      assign special[gi] = match[gi] & (mode_sel[gi] == `MODE_SPECIAL);

      compare_channel u_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_sel[gi]),
        .ctrl_zero_wr(ctrl_zero_wr[gi]),
        .compare_value(value_reg[gi]),
        .count(sel_count),
        .tick(sel_tick),
        .match(match[gi]),
        .compare_latch(compare_latch[gi])
      );

      duty_pwm #(
        .DUTY_W(DUTY_W)
      ) u_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .enable(pwm_mode[gi]),
        .duty(duty),
        .fine_count(pwm_fine_count),
        .period_start(pwm_period_start),
        .pwm_out(pwm_out[gi])
      );

      // value and control storage for this channel
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          value_reg[gi] <= {`RST_BYTE, `RST_BYTE};
          control_reg[gi] <= `RST_BYTE;
        end else begin
          if (low_wr[gi]) begin
            value_reg[gi][7:0] <= pwdata[7:0];
          end
          // the high byte takes no writes while the channel is in pwm mode; duty comes from the low byte
          if (high_wr[gi] && !pwm_mode[gi]) begin
            value_reg[gi][15:8] <= pwdata[7:0];
          end
          if (ctrl_wr[gi]) begin
            if (gi == 1) begin
              control_reg[gi] <= {2'b00, pwdata[5:0]};
            end else begin
              control_reg[gi] <= pwdata[7:0];
            end
          end
        end
      end
    end
  endgenerate

  // timer select register; unused bits are plain storage for software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_timer_control_reg <= `RST_BYTE;
    end else if (wr_en && (paddr == `OFS_SECOND_TIMER_CONTROL)) begin
      second_timer_control_reg <= pwdata[7:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always @* begin
    match_flag_next = match_flag_reg;
    if (wr_en && (paddr == `OFS_MATCH_STATUS)) begin
      match_flag_next = match_flag_reg & ~pwdata[1:0];
    end
    match_flag_next = match_flag_next | match;
  end

  // flags and enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_reg <= 2'b00;
      match_irq_enable_reg <= 2'b00;
    end else begin
      match_flag_reg <= match_flag_next;
      if (wr_en && (paddr == `OFS_MATCH_ENABLE)) begin
        match_irq_enable_reg <= pwdata[1:0];
      end
    end
  end

  // read mux; unmapped addresses answer with an error and zero data
  always @* begin
    rd_data = `RST_WORD;
    addr_hit = 1'b1;
    case (paddr)
      `OFS_SECOND_TIMER_CONTROL: rd_data[7:0] = second_timer_control_reg;
      `OFS_UNIT_ONE_VALUE_LOW: rd_data[7:0] = value_reg[0][7:0];
      `OFS_UNIT_ONE_VALUE_HIGH: rd_data[7:0] = value_reg[0][15:8];
      `OFS_UNIT_ONE_CONTROL: rd_data[7:0] = control_reg[0];
      `OFS_UNIT_TWO_VALUE_LOW: rd_data[7:0] = value_reg[1][7:0];
      `OFS_UNIT_TWO_VALUE_HIGH: rd_data[7:0] = value_reg[1][15:8];
      `OFS_UNIT_TWO_CONTROL: rd_data[7:0] = control_reg[1];
      `OFS_MATCH_STATUS: rd_data[1:0] = match_flag_reg;
      `OFS_MATCH_ENABLE: rd_data[1:0] = match_irq_enable_reg;
      default: addr_hit = 1'b0;
    endcase
  end

  // apb answer: data and ready are registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? `RST_WORD : rd_data;
      pready <= 1'b1;
      pslverr <= ~addr_hit;
    end else if (access_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // trigger outputs: one-cycle pulses, one cycle after the match edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_time_base_clear <= 1'b0;
      second_time_base_clear <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      first_time_base_clear <= |(special & ~use_second);
      second_time_base_clear <= |(special & use_second);
      // the converter ignores this unless software enabled it first
      adc_start <= special[1];
    end
  end

  // interrupt request gated by enable; flag stays for software to clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 2'b00;
    end else begin
      irq_req <= match_flag_reg & match_irq_enable_reg;
    end
  end

  // pin mux: pwm, then compare latch, else the ordinary port latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_pin_out <= 2'b00;
      channel_pin_oe <= 2'b00;
    end else begin
      // direction is software's job; the unit only follows it
      channel_pin_oe <= ~pin_direction_bits;
      channel_pin_out <= (pwm_mode & pwm_out) |
                         (~pwm_mode & pin_mode & compare_latch) |
                         (~pwm_mode & ~pin_mode & port_latch);
    end
  end

endmodule // timer_compare_unit

// ### tb/timer_compare_unit_assertions.sv
/*
  port-level checker for the compare unit.
  assumes the map header and a single pclk domain.
*/
`timescale 1ns/1ps
`include "timer_compare_map.vh"
module timer_compare_unit_checker #(
  parameter ADDR_W = 8,
  parameter DUTY_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire first_time_base_tick,
  input wire second_time_base_tick,
  input wire [1:0] pin_direction_bits,
  input wire [1:0] channel_pin_oe,
  input wire [1:0] irq_req,
  input wire first_time_base_clear,
  input wire second_time_base_clear,
  input wire adc_start
);
  logic [1:0] en_sh; // shadow of the match enable register
  // tracks completed writes so irq can be tied to the enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) en_sh <= 2'b00;
    else if (psel && penable && pready && pwrite && paddr == `OFS_MATCH_ENABLE) en_sh <= pwdata[1:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready && psel && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("error read not zero");
  property p_bits; pready && !pwrite |-> prdata[31:8] == 24'h00_0000
    && (paddr != `OFS_UNIT_TWO_CONTROL || prdata[7:6] == 2'b00); endproperty
  a_bits: assert property (p_bits) else $error("unused bits read set");
  property p_oe; $past(presetn) |-> channel_pin_oe == ~$past(pin_direction_bits); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_irq; (irq_req & ~$past(en_sh)) == 2'b00; endproperty
  a_irq: assert property (p_irq) else $error("irq while disabled");
  // the clear pulse is registered at the match edge, so the tick stood one edge back
  property p_clr1; first_time_base_clear |-> $past(first_time_base_tick); endproperty
  a_clr1: assert property (p_clr1) else $error("clear without tick");
  property p_clr2; second_time_base_clear |-> $past(second_time_base_tick); endproperty
  a_clr2: assert property (p_clr2) else $error("clear without tick");
  property p_adc; adc_start |-> (first_time_base_clear || second_time_base_clear) ##1 !adc_start;
  endproperty
  a_adc: assert property (p_adc) else $error("start without clear");
  c_adc: cover property (adc_start);
  c_irq: cover property (irq_req != 2'b00);
  c_err: cover property (pslverr);
endmodule // timer_compare_unit_checker
bind timer_compare_unit timer_compare_unit_checker #(.ADDR_W(ADDR_W), .DUTY_W(DUTY_W))
  timer_compare_unit_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .first_time_base_tick(first_time_base_tick),
  .second_time_base_tick(second_time_base_tick), .pin_direction_bits(pin_direction_bits),
  .channel_pin_oe(channel_pin_oe), .irq_req(irq_req),
  .first_time_base_clear(first_time_base_clear),
  .second_time_base_clear(second_time_base_clear), .adc_start(adc_start));

// ### tb/timer_compare_unit_tb.sv
/*
  bench for the compare unit: registers, compare modes, timer select, events.
  assumes the map header and the timer model; pwm inputs are driven only for the channel one pwm check.
*/
`timescale 1ns/1ps
`include "timer_compare_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module timer_compare_unit_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, tk1, tk2, c1, c2, adc;
  logic [15:0] t1, t2;
  logic [1:0] latch = 0, dir = 0, pin, oe, irq;
  logic [9:0] fc = 0; // pwm fine count driven by the bench
  logic ps = 0; // pwm period start pulse
  logic [3:0] modes [7] = '{`MODE_SET_HIGH, `MODE_OFF, `MODE_TOGGLE, `MODE_SET_LOW,
    `MODE_TOGGLE, `MODE_SOFT_IRQ, `MODE_SPECIAL};
  logic [7:0] sel [3] = '{8'h00, 8'h08, 8'h40};
  int err_total = 0, total_checks = 0, cyc = 0, n1 = 0, n2 = 0, na = 0, seed = 32'h0000_4646;
  always #2 pclk = ~pclk;
  timer_compare_unit timer_compare_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_time_base(t1), .first_time_base_tick(tk1),
    .second_time_base(t2), .second_time_base_tick(tk2), .pwm_fine_count(fc),
    .pwm_period_start(ps), .port_latch(latch), .pin_direction_bits(dir),
    .channel_pin_out(pin), .channel_pin_oe(oe), .irq_req(irq), .first_time_base_clear(c1),
    .second_time_base_clear(c2), .adc_start(adc));
  timer_model timer_model_i (.pclk(pclk), .presetn(presetn), .slow(slow), .clr1(c1),
    .clr2(c2), .cnt1(t1), .cnt2(t2), .tk1(tk1), .tk2(tk2));
  // event counters and the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n1 <= n1 + c1;
    n2 <= n2 + c2;
    na <= na + adc;
    if (cyc == 40000) begin
      err_total++;
      conclude;
    end
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer, then one idle cycle so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic nxt(input logic [3:0] m, input logic l);
    return (m == `MODE_SET_HIGH) ? 1'b1 : (m == `MODE_TOGGLE) ? ~l :
      (m == `MODE_SET_LOW || m == `MODE_OFF) ? 1'b0 : l;
  endfunction
  function automatic logic pexp(input logic [3:0] m, input logic l, input logic p);
    return (m == `MODE_TOGGLE || m == `MODE_SET_HIGH || m == `MODE_SET_LOW) ? l : p;
  endfunction
  // walks every compare mode on one channel; zero control write resets the latch
  task automatic run(input int ch, input logic [7:0] ts);
    logic [7:0] base;
    logic lat;
    logic use2;
    logic sp;
    logic [1:0] e;
    int b1, b2, ba;
    base = 8'h04 + 8'(ch * 12);
    lat = 1'b0;
    use2 = ts[6] || (ts[3] && ch == 1);
    apb(1, base, 32'(20 + ($random(seed) & 15)));
    apb(1, base + 8'h04, '0);
    foreach (modes[i]) begin
      e = 2'($random(seed));
      latch <= 2'($random(seed));
      sp = modes[i] == `MODE_SPECIAL;
      apb(1, `OFS_MATCH_ENABLE, 32'(e));
      b1 = n1;
      b2 = n2;
      ba = na;
      apb(1, base + 8'h08, 32'(modes[i]));
      lat = nxt(modes[i], lat);
      if (modes[i] != `MODE_OFF) begin
        rd = '0;
        for (int k = 0; k < 120 && rd[ch] !== 1'b1; k++) apb(0, `OFS_MATCH_STATUS, '0);
        `CHK(rd[ch], 1'b1)
        `CHK(pin[ch], pexp(modes[i], lat, latch[ch]))
        apb(0, `OFS_MATCH_STATUS, '0);
        `CHK(rd[ch], 1'b1)
        `CHK(irq[ch], e[ch])
        apb(1, `OFS_MATCH_STATUS, 32'(1 << ch));
      end
      `CHK(n1 - b1, int'(sp && !use2))
      `CHK(n2 - b2, int'(sp && use2))
      `CHK(na - ba, int'(sp && ch == 1))
    end
    apb(1, base + 8'h08, '0);
  endtask
  initial begin
    dir <= 2'($random(seed));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a <= 36; a += 4) begin
      apb(0, 8'(a), '0);
      `CHK(rd, 32'h0000_0000)
      `CHK(err, a == 36)
    end
    apb(1, `OFS_UNIT_TWO_CONTROL, 32'h0000_00FF);
    apb(0, `OFS_UNIT_TWO_CONTROL, '0);
    `CHK(rd, 32'h0000_003F)
    apb(1, `OFS_UNIT_TWO_CONTROL, '0);
    dir <= 2'b00;
    // pwm on channel one: duty {01,00} = 4, high at period start, low at fine count 4
    apb(1, `OFS_UNIT_ONE_VALUE_LOW, 32'h0000_0001);
    apb(1, `OFS_UNIT_ONE_CONTROL, 32'h0000_000C);
    apb(1, `OFS_UNIT_ONE_VALUE_HIGH, 32'h0000_0055);
    apb(0, `OFS_UNIT_ONE_VALUE_HIGH, '0);
    `CHK(rd, 32'h0000_0000)
    ps <= 1'b1;
    fc <= 10'h000;
    @(posedge pclk);
    ps <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(pin[0], 1'b1)
    fc <= 10'h004;
    repeat (3) @(posedge pclk);
    `CHK(pin[0], 1'b0)
    apb(1, `OFS_UNIT_ONE_CONTROL, '0);
    foreach (sel[s]) begin
      slow <= s[0];
      apb(1, `OFS_SECOND_TIMER_CONTROL, 32'(sel[s]));
      for (int ch = 0; ch < 2; ch++) run(ch, sel[s]);
    end
    conclude;
  end
endmodule // timer_compare_unit_tb

// ### tb/timer_model.sv
/*
  two free-running time bases for the compare unit, with increment ticks.
  assumes the unit's clear pulses arrive on pclk; counts wrap at TOP.
*/
`timescale 1ns/1ps
module timer_model #(
  parameter TOP = 63
) (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire clr1,
  input wire clr2,
  output logic [15:0] cnt1,
  output logic [15:0] cnt2,
  output logic tk1,
  output logic tk2
);
  logic ph; // phase for slow stepping
  logic half; // second base steps at half rate, so it holds each value
  wire step = !slow || ph;
  wire step2 = step && half;
  // counting on pclk only, never as an asynchronous counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cnt1, cnt2, tk1, tk2, ph, half} <= '0;
    end else begin
      ph <= ~ph;
      half <= half ^ step;
      tk1 <= step && !clr1;
      tk2 <= step2 && !clr2;
      if (clr1) cnt1 <= 16'h0000;
      else if (step) cnt1 <= (cnt1 == TOP) ? 16'h0000 : cnt1 + 16'h0001;
      if (clr2) cnt2 <= 16'h0000;
      else if (step2) cnt2 <= (cnt2 == TOP) ? 16'h0000 : cnt2 + 16'h0001;
    end
  end
endmodule // timer_model
